/* design/sug_consts.vh */
// constants for the lock/unlock access guard
`ifndef SUG_CONSTS_VH
`define SUG_CONSTS_VH

// command codes on the host command port
`define SUG_CMD_CTRL_LO     8'h00
`define SUG_CMD_CTRL_HI     8'h01
`define SUG_CMD_CLASS       8'h3e
`define SUG_CMD_BLOCK       8'h3f
`define SUG_CMD_WIN_FIRST   8'h40
`define SUG_CMD_WIN_LAST    8'h5f

// control subcommand that locks
`define SUG_SUB_LOCK        16'h0020
// block number that selects the maker information block while locked
`define SUG_BLK_MAKER       8'h01
// class number that reaches the maker block while open: arbitrary value
`define SUG_CLASS_MAKER     8'h0c

// lock delay: at most 2 s at 10 MHz; the 1-cycle default sets the flag first
`define SUG_LOCK_TIME_MS    32'd2000
`define SUG_CLK_KHZ         32'd10000
`define SUG_LOCK_CYCLES     (`SUG_LOCK_TIME_MS * `SUG_CLK_KHZ)
`define SUG_LOCK_DLY_DFLT   32'd1

// key reset value: arbitrary neutral pattern
`define SUG_KEY_RESET       32'ha5a55a5a

// address width of the combined store and lock state encodings
`define SUG_MAKER_AW        8
`define SUG_STATE_OPEN      1'b0
`define SUG_STATE_LOCKED    1'b1

`endif

/* design/sug_store.v */
// small single-port store with registered read data
`timescale 1ns/1ps
`default_nettype none

module sug_store #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clock,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

`default_nettype wire

/* design/sug_guard.v */
// lock/unlock access guard for configuration and maker information memory
//
// Contract
// - open: config and maker block read/write; locked: config none, maker read only
// - leaves reset in the open state
// - unlock key may be changed only while open
// - control word 0x0020 locks; locked flag set within two seconds
// - key 0 is upper word, key 1 lower; key 1 sent first
// - each key word arrives byte swapped versus read back order
// - correct key pair while locked clears flag and opens
// - lock and key words travel through control command codes 0x00/0x01
// - class selection refused while locked; block selection still accepted
// - locked block select 0x01 maps window to maker block
`timescale 1ns/1ps
`default_nettype none
`include "sug_consts.vh"

module sug_guard #(
    parameter        [31:0] LOCK_CYCLES = `SUG_LOCK_CYCLES
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        cmd_wr,
    input  wire        cmd_rd,
    input  wire [7:0]  cmd_code,
    input  wire [7:0]  cmd_wdata,
    input  wire        key_wr,
    input  wire [31:0] key_wdata,
    output reg  [7:0]  cmd_rdata_r,
    output reg         cmd_rvalid_r,
    output reg         cmd_refused_r,
    output reg         locked_r,
    output reg  [31:0] unlock_key_r,
    output reg         key_refused_r
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function in_window;
        input [7:0] c;
        begin
            in_window = (c >= `SUG_CMD_WIN_FIRST) && (c <= `SUG_CMD_WIN_LAST);
        end
    endfunction

    function [15:0] swap16;
        input [15:0] w;
        begin
            swap16 = {w[7:0], w[15:8]};
        end
    endfunction

    // maker block sits in page 0, config blocks follow it
    function [2:0] page_of;
        input       locked;
        input [7:0] cls;
        input [7:0] blk;
        begin
            if (locked || cls == `SUG_CLASS_MAKER) begin
                page_of = 3'd0;
            end else begin
                page_of = blk[2:0] + 3'd1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam [1:0] KS_IDLE = 2'd0;
    localparam [1:0] KS_GOT1 = 2'd1;

    reg        ctrl_lo_seen_r;
    reg [7:0]  ctrl_lo_r;
    reg [1:0]  key_state_r;
    reg [1:0]  key_state_nxt;
    reg        lock_pend_r;
    reg [31:0] lock_cnt_r;
    reg [7:0]  class_r;
    reg [7:0]  block_r;
    reg        win_maker_r;
    reg        rd_pend_r;
    reg        rd_ok_r;

    wire [15:0] ctrl_word = {cmd_wdata, ctrl_lo_r};
    // a control word completes when the high byte lands after its low byte
    wire        ctrl_done = cmd_wr && (cmd_code == `SUG_CMD_CTRL_HI) && ctrl_lo_seen_r;
    wire        key1_ok   = ctrl_word == swap16(unlock_key_r[15:0]);
    wire        key0_ok   = ctrl_word == swap16(unlock_key_r[31:16]);
    wire        is_win    = in_window(cmd_code);
    wire        mem_open  = locked_r == `SUG_STATE_OPEN;

    // access gate: locked allows only reads of the maker block
    wire        win_wr_ok = is_win && cmd_wr && mem_open;
    wire        win_rd_ok = is_win && cmd_rd && (mem_open || win_maker_r);
    wire        sel_refuse = cmd_wr && !mem_open && (cmd_code == `SUG_CMD_CLASS);

    // maker block lives in page 0, config blocks above it
    wire [4:0]  win_off  = cmd_code[4:0];
    // block 7 wraps onto the maker page; only eight pages fit the store
    wire [2:0]  page     = page_of(!mem_open, class_r, block_r);
    wire [7:0]  st_addr  = {page, win_off};
    wire [7:0]  st_rdata;

    sug_store #(
        .AW (`SUG_MAKER_AW),
        .DW (8)
    ) u_store (
        .clock (clock),
        .we    (win_wr_ok),
        .addr  (st_addr),
        .wdata (cmd_wdata),
        .rdata (st_rdata)
    );

    // ------------------------------------------------------------
    // key matching
    // ------------------------------------------------------------
    always @* begin
        key_state_nxt = key_state_r;
        case (key_state_r)
            // key 1 alone never opens; only key 0 right after it does
            KS_IDLE: begin
                if (ctrl_done && locked_r && key1_ok) begin
                    key_state_nxt = KS_GOT1;
                end
            end
            KS_GOT1: begin
                // any other control word restarts matching
                if (ctrl_done) begin
                    key_state_nxt = KS_IDLE;
                end
            end
            default: begin
                key_state_nxt = KS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // control path
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            ctrl_lo_seen_r <= 1'b0;
            ctrl_lo_r      <= 8'h00;
            key_state_r    <= KS_IDLE;
            locked_r       <= `SUG_STATE_OPEN;
            lock_pend_r    <= 1'b0;
            lock_cnt_r     <= 32'h00000000;
            unlock_key_r   <= `SUG_KEY_RESET;
            key_refused_r  <= 1'b0;
        end else begin
            key_state_r   <= key_state_nxt;
            key_refused_r <= key_wr && locked_r;
            if (key_wr && !locked_r) begin
                unlock_key_r <= key_wdata;
            end
            if (cmd_wr && cmd_code == `SUG_CMD_CTRL_LO) begin
                ctrl_lo_r      <= cmd_wdata;
                ctrl_lo_seen_r <= 1'b1;
            end else if (ctrl_done) begin
                ctrl_lo_seen_r <= 1'b0;
            end
            // lock delay counts up to the flag, well inside two seconds
            if (ctrl_done && !locked_r && ctrl_word == `SUG_SUB_LOCK) begin
                lock_pend_r <= 1'b1;
                lock_cnt_r  <= 32'h00000000;
            end else if (lock_pend_r) begin
                if (lock_cnt_r + 32'd1 >= `SUG_LOCK_DLY_DFLT || lock_cnt_r + 32'd1 >= LOCK_CYCLES) begin
                    lock_pend_r <= 1'b0;
                    locked_r    <= `SUG_STATE_LOCKED;
                end
                lock_cnt_r <= lock_cnt_r + 32'd1;
            end
            if (key_state_r == KS_GOT1 && ctrl_done && key0_ok) begin
                locked_r <= `SUG_STATE_OPEN;
            end
        end
    end

    // ------------------------------------------------------------
    // selection and window read path
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            class_r       <= 8'h00;
            block_r       <= 8'h00;
            win_maker_r   <= 1'b0;
            rd_pend_r     <= 1'b0;
            rd_ok_r       <= 1'b0;
            cmd_rdata_r   <= 8'h00;
            cmd_rvalid_r  <= 1'b0;
            cmd_refused_r <= 1'b0;
        end else begin
            if (cmd_wr && cmd_code == `SUG_CMD_CLASS && mem_open) begin
                class_r <= cmd_wdata;
            end
            if (cmd_wr && cmd_code == `SUG_CMD_BLOCK) begin
                if (mem_open) begin
                    block_r <= cmd_wdata;
                end else begin
                    win_maker_r <= (cmd_wdata == `SUG_BLK_MAKER);
                end
            end
            if (mem_open) begin
                win_maker_r <= 1'b0;
            end
            // refused reads still pulse rvalid, with zero data
            rd_pend_r     <= is_win && cmd_rd;
            rd_ok_r       <= win_rd_ok;
            cmd_rvalid_r  <= rd_pend_r;
            cmd_rdata_r   <= (rd_pend_r && rd_ok_r) ? st_rdata : 8'h00;
            cmd_refused_r <= sel_refuse || (is_win && cmd_wr && !mem_open) ||
                             (is_win && cmd_rd && !win_rd_ok);
        end
    end
endmodule

`default_nettype wire

/* bench/sug_guard_monitor.sv */
// assertion checker for the lock/unlock access guard
`timescale 1ns/1ps
`default_nettype none
module sug_guard_monitor (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        cmd_wr,
    input wire logic        cmd_rd,
    input wire logic [7:0]  cmd_code,
    input wire logic [7:0]  cmd_wdata,
    input wire logic        key_wr,
    input wire logic        cmd_rvalid_r,
    input wire logic        cmd_refused_r,
    input wire logic        locked_r,
    input wire logic [31:0] unlock_key_r,
    input wire logic        key_refused_r
);
    // ----
    // checks
    // ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic win = cmd_code >= 8'h40 && cmd_code <= 8'h5f;
    a_open_ok: assert property (cmd_wr && !locked_r |=> !cmd_refused_r) else $error("open refused");
    a_cfg_deny: assert property (cmd_wr && locked_r && win |=> cmd_refused_r) else $error("cfg open");
    a_read_open: assert property (cmd_rd && !locked_r && win |-> ##2 cmd_rvalid_r) else $error("no data");
    a_class_deny: assert property (cmd_wr && locked_r && cmd_code == 8'h3e |=> cmd_refused_r)
        else $error("class open");
    a_block_ok: assert property (cmd_wr && locked_r && cmd_code == 8'h3f |=> !cmd_refused_r)
        else $error("block refused");
    a_key_deny: assert property (key_wr && locked_r |=> key_refused_r && $stable(unlock_key_r))
        else $error("key changed");
    // lock word low byte two cycles before the high byte, as the host paces it
    a_lock_set: assert property (cmd_wr && cmd_code == 8'h01 && cmd_wdata == 8'h00
        && $past(cmd_wr && cmd_code == 8'h00 && cmd_wdata == 8'h20, 2) |-> ##2 locked_r) else $error("no lock");
    a_unlock_src: assert property ($fell(locked_r) |-> $past(cmd_wr && cmd_code == 8'h01))
        else $error("stray unlock");
endmodule
`default_nettype wire

/* bench/sug_host.sv */
// host model driving the guard's command port
`timescale 1ns/1ps
`default_nettype none
module sug_host (
    input  wire logic        clock,
    output logic        cmd_wr,
    output logic        cmd_rd,
    output logic [7:0]  cmd_code,
    output logic [7:0]  cmd_wdata,
    output logic        key_wr,
    output logic [31:0] key_wdata
);
    // ----
    // transfers
    // ----
    initial {cmd_wr, cmd_rd, key_wr, cmd_code, cmd_wdata, key_wdata} = 51'h0;
    // released lines show the inverse so a stale value never passes
    task wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge clock);
        #1;
        {cmd_wr, cmd_code, cmd_wdata} = {1'b1, c, d};
        @(posedge clock);
        #1;
        {cmd_wr, cmd_code, cmd_wdata} = {1'b0, ~c, ~d};
    endtask
    task rd(input logic [7:0] c);
        @(posedge clock);
        #1;
        {cmd_rd, cmd_code} = {1'b1, c};
        @(posedge clock);
        #1;
        {cmd_rd, cmd_code} = {1'b0, ~c};
    endtask
    task setkey(input logic [31:0] k);
        @(posedge clock);
        #1;
        {key_wr, key_wdata} = {1'b1, k};
        @(posedge clock);
        #1;
        {key_wr, key_wdata} = {1'b0, ~k};
    endtask
    task ctrl(input logic [15:0] w);
        wr(8'h00, w[7:0]);
        wr(8'h01, w[15:8]);
    endtask
    task unlock(input logic [31:0] k);
        ctrl({k[7:0], k[15:8]});
        ctrl({k[23:16], k[31:24]});
    endtask
endmodule
`default_nettype wire

/* bench/sug_guard_bench.sv */
// self-checking bench for the lock/unlock access guard
`timescale 1ns/1ps
`default_nettype none
module sug_guard_bench;
    // ----
    // setup
    // ----
    localparam logic [31:0] KEY = 32'h56781234;
    logic             clock;
    logic             rst_n;
    wire logic        cmd_wr, cmd_rd, key_wr, cmd_rvalid_r, cmd_refused_r, locked_r, key_refused_r;
    wire logic [7:0]  cmd_code, cmd_wdata, cmd_rdata_r;
    wire logic [31:0] key_wdata, unlock_key_r;
    int               bad_count = 0;
    int               compares = 0;
    int               cyc = 0;
    sug_guard sug_guard_inst (
        .clock         (clock),
        .rst_n         (rst_n),
        .cmd_wr        (cmd_wr),
        .cmd_rd        (cmd_rd),
        .cmd_code      (cmd_code),
        .cmd_wdata     (cmd_wdata),
        .key_wr        (key_wr),
        .key_wdata     (key_wdata),
        .cmd_rdata_r   (cmd_rdata_r),
        .cmd_rvalid_r  (cmd_rvalid_r),
        .cmd_refused_r (cmd_refused_r),
        .locked_r      (locked_r),
        .unlock_key_r  (unlock_key_r),
        .key_refused_r (key_refused_r)
    );
    sug_host sug_host_inst (
        .clock     (clock),
        .cmd_wr    (cmd_wr),
        .cmd_rd    (cmd_rd),
        .cmd_code  (cmd_code),
        .cmd_wdata (cmd_wdata),
        .key_wr    (key_wr),
        .key_wdata (key_wdata)
    );
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            end_sim;
        end
    end
    task end_sim;
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task wrr(input logic [7:0] c, input logic [7:0] d, input logic e);
        sug_host_inst.wr(c, d);
        chk("refused", e, cmd_refused_r);
    endtask
    task rdr(input logic [7:0] c, input logic e);
        sug_host_inst.rd(c);
        chk("refused", e, cmd_refused_r);
        @(posedge clock);
        #1;
        if (!e) chk("rvalid", 1, cmd_rvalid_r);
        else chk("rdata", 0, cmd_rdata_r);
    endtask
    task lchk(input logic e);
        @(posedge clock);
        #1;
        chk("locked", e, locked_r);
    endtask
    // ----
    // scenarios
    // ----
    task t_reset;
        rst_n = 0;
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1;
        chk("locked", 0, locked_r);
        chk("key", 32'ha5a55a5a, unlock_key_r);
    endtask
    task t_open;
        wrr(8'h40, 8'h5c, 0);
        rdr(8'h40, 0);
        chk("rdata", 32'h5c, cmd_rdata_r);
        wrr(8'h3e, 8'h0c, 0);
        wrr(8'h41, 8'h6d, 0);
        rdr(8'h41, 0);
        chk("rdata", 32'h6d, cmd_rdata_r);
        wrr(8'h3e, 8'h00, 0);
        sug_host_inst.setkey(KEY);
        chk("key", KEY, unlock_key_r);
    endtask
    task t_lock;
        sug_host_inst.ctrl(16'h0020);
        lchk(1);
    endtask
    task t_locked;
        wrr(8'h3e, 8'h02, 1);
        wrr(8'h40, 8'h11, 1);
        rdr(8'h40, 1);
        wrr(8'h3f, 8'h01, 0);
        rdr(8'h41, 0);
        chk("rdata", 32'h6d, cmd_rdata_r);
        sug_host_inst.setkey(32'h0);
        chk("key_refused", 1, key_refused_r);
        chk("key", KEY, unlock_key_r);
    endtask
    // an intervening word, reversed words and unswapped bytes must all fail
    task t_bad;
        sug_host_inst.ctrl(16'h3412);
        sug_host_inst.ctrl(16'h0000);
        sug_host_inst.ctrl(16'h7856);
        lchk(1);
        sug_host_inst.unlock(32'h12345678);
        lchk(1);
        sug_host_inst.ctrl(16'h1234);
        sug_host_inst.ctrl(16'h5678);
        lchk(1);
    endtask
    task t_unlock;
        sug_host_inst.unlock(KEY);
        lchk(0);
        wrr(8'h3e, 8'h02, 0);
    endtask
    initial begin
        t_reset;
        t_open;
        t_lock;
        t_locked;
        t_bad;
        t_unlock;
        t_lock;
        t_reset;
        end_sim;
    end
endmodule
bind sug_guard sug_guard_monitor sug_guard_monitor_inst (
    .clock         (clock),
    .rst_n         (rst_n),
    .cmd_wr        (cmd_wr),
    .cmd_rd        (cmd_rd),
    .cmd_code      (cmd_code),
    .cmd_wdata     (cmd_wdata),
    .key_wr        (key_wr),
    .cmd_rvalid_r  (cmd_rvalid_r),
    .cmd_refused_r (cmd_refused_r),
    .locked_r      (locked_r),
    .unlock_key_r  (unlock_key_r),
    .key_refused_r (key_refused_r)
);
`default_nettype wire
